//--- hw/dar_pkg.sv
// Purpose: constants for the divider, alarm and reset control block
// Assumes: one clock pclk at 250 MHz, APB register access
// Notes: register offsets are byte addresses of aligned words
package dar_pkg;
    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_ALARM_CTRL = 8'h00;
    localparam logic [7:0] ADDR_OSC_CTRL = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_DIVIDER = 8'h0c;
    localparam logic [7:0] ADDR_OUT_CTRL = 8'h10;
    // alarm control fields
    localparam int ALM_MODE_LSB = 0;
    localparam int ALM_LOSEL_LSB = 2;
    localparam int ALM_HIMASK_LSB = 4;
    localparam int ALM_MODSEL_LSB = 10;
    localparam int ALM_MOD_EN_BIT = 12;
    localparam int ALM_SRC_BIT = 13;
    // oscillator control fields
    localparam int OSC_STOP_BIT = 0;
    // status fields
    localparam int ST_RESET_BIT = 0;
    localparam int ST_STOP_BIT = 1;
    localparam int ST_OSCOPT_LSB = 4;
    // reset values
    localparam logic [31:0] ALARM_CTRL_RST = 32'h0000_0000;
    localparam logic [3:0] OUT_CTRL_RST = 4'h0;
    // ------------------------------------------------------------
    // oscillator options and cycle divisions
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        OSC_RC_XTAL = 3'h0,
        OSC_CF_XTAL = 3'h1,
        OSC_RC = 3'h2,
        OSC_CF = 3'h3,
        OSC_XTAL = 3'h4
    } dar_osc_type;
    localparam int RC_CYCLE_DIV = 4;
    localparam int CF_CYCLE_DIV = 16;
    localparam int XTAL_CYCLE_DIV = 4;
    // alarm output modes
    localparam logic [1:0] ALM_MODE_STATIC = 2'h0;
    localparam logic [1:0] ALM_MODE_LOW = 2'h1;
    localparam logic [1:0] ALM_MODE_HIGH = 2'h2;
    // divider stages
    localparam int DIV_STAGES = 15;
    localparam int LOW_TAP_BASE = 3;
    localparam int HIGH_TAP_BASE = 10;
    localparam int HIGH_TAPS = 6;
    // modulating taps: 4k, 2k, 1k from a 32.768 kHz crystal
    localparam int MOD_TAP_4K = 3;
    localparam int MOD_TAP_2K = 4;
    localparam int MOD_TAP_1K = 5;
    // reset clears divider stages up to this one, overflow from it
    localparam int RST_CLR_STAGES = 15;
    // ------------------------------------------------------------
    // reset controller states
    // ------------------------------------------------------------
    typedef enum logic [2:0]
    {
        ST_POR = 3'b001,
        ST_HOLD = 3'b010,
        ST_RUN = 3'b100
    } dar_rst_type;
endpackage : dar_pkg

//--- hw/dar_top.sv
// Purpose: divider, alarm and reset control of a small lcd controller
// Assumes: the oscillators arrive as one-cycle enables on pclk
// Notes: how it works listed below
// How it works
// - dedicated outputs show option levels while reset holds
// - alarm can send 4k, 2k or 1k modulated tones, or plain
// - alarm can carry one divider tap at stage 3, 4 or 5
// - alarm can carry any combination of taps at stages 10 to 15
// - modulated form of the low tap or the high-tap combination
// - rc options give an instruction cycle of four primary periods
// - ceramic options give sixteen primary periods per cycle
// - crystal-only option gives four crystal periods per cycle
// - divider taps feed timer clock, lcd timing and divider events
// - stop instruction halts the rc oscillator
// - reset from power-on clear, reset pin, or all four switches
// - power-on clear resets logic at power-up when enabled
// - power-on clear enabled or disabled by build option
// - reset pin sets reset flag and clears whole divider
// - logic held while flag set; after power-on clear or a request only divider overflow clears it
// - on flag clear, logic reset released and counter may advance
// - all switches at supply level clear logic when enabled
// - lcd commons and segments show static all on or all off
// - reset pin polarity chosen by build option
//
// The APB register port and the register offsets were left to the implementer.
`timescale 1ns/1ps
module dar_top
    import dar_pkg::*;
#(
    parameter dar_osc_type OSC_OPTION = OSC_RC_XTAL,
    parameter bit POR_ENABLE = 1'b1,
    parameter bit SWITCH_RESET_ENABLE = 1'b1,
    parameter bit RESET_ACTIVE_HIGH = 1'b1,
    parameter bit AUX1_RESET_LEVEL = 1'b0,
    parameter bit AUX2_RESET_LEVEL = 1'b0,
    parameter bit LIGHT_RESET_LEVEL = 1'b0,
    parameter bit ALARM_RESET_LEVEL = 1'b0,
    parameter bit LCD_ALL_ON = 1'b0,
    parameter int SEGMENTS = 42
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // oscillator ticks
    input wire logic primary_osc_tick,
    input wire logic crystal_tick,
    output logic rc_osc_run,
    // reset sources
    input wire logic external_reset_pin,
    input wire logic switch_input_1,
    input wire logic switch_input_2,
    input wire logic switch_input_3,
    input wire logic switch_input_4,
    // core timing
    output logic cycle_strobe,
    output logic logic_reset,
    output logic [DIV_STAGES:1] divider_tap,
    output logic timer_clock,
    output logic lcd_timing,
    output logic divider_event,
    // dedicated outputs
    output logic aux_output_1,
    output logic aux_output_2,
    output logic light_output,
    output logic alarm_output,
    // lcd static levels during reset
    output logic lcd_reset_force,
    output logic [3:1] lcd_common_level,
    output logic [SEGMENTS-1:0] segment_level
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [31:0] alarm_ctrl;
    logic [3:0] out_ctrl;
    logic [DIV_STAGES:1] div_cnt, next_div;
    logic [4:0] cyc_cnt, cyc_last;
    logic osc_stop, div_overflow, cyc_tick;
    logic rst_pin_s1, rst_pin_s2, sw_s1, sw_s2;
    logic rst_request, reset_flag;
    dar_rst_type rst_state;
    logic alarm_raw, alarm_mod, low_tap, high_comb;
    logic apb_wr, apb_rd;

    // ------------------------------------------------------------
    // instruction cycle division
    // ------------------------------------------------------------
    always_comb
    begin
        case (OSC_OPTION)
            OSC_RC_XTAL, OSC_RC:
                cyc_last = 5'(RC_CYCLE_DIV - 1);
            OSC_CF_XTAL, OSC_CF:
                cyc_last = 5'(CF_CYCLE_DIV - 1);
            default:
                cyc_last = 5'(XTAL_CYCLE_DIV - 1);
        endcase
    end

    // crystal-only counts crystal periods, others primary periods
    assign cyc_tick = (OSC_OPTION == OSC_XTAL) ? crystal_tick :
        (primary_osc_tick & rc_osc_run);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            cyc_cnt <= 5'h00;
        else if (cyc_tick)
            cyc_cnt <= (cyc_cnt == cyc_last) ? 5'h00 : cyc_cnt + 5'h01;
    end

    assign cycle_strobe = cyc_tick & (cyc_cnt == cyc_last) & ~logic_reset;

    // rc oscillator stops on software request; reset restarts it
    assign rc_osc_run = ~osc_stop;

    // ------------------------------------------------------------
    // ripple divider, modelled as a synchronous counter
    // ------------------------------------------------------------
    // divider counts crystal ticks if fitted, else primary ticks
    logic div_tick;
    assign div_tick = (OSC_OPTION == OSC_RC || OSC_OPTION == OSC_CF) ?
        (primary_osc_tick & rc_osc_run) : crystal_tick;

    always_comb
    begin
        next_div = div_cnt;
        if (div_tick)
            next_div = div_cnt + 15'h0001;
        if (rst_request)
            next_div = '0;
    end

    assign div_overflow = div_tick & (&div_cnt[RST_CLR_STAGES:1]);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            div_cnt <= '0;
        else
            div_cnt <= next_div;
    end

    assign divider_tap = div_cnt;
    assign timer_clock = div_cnt[HIGH_TAP_BASE];
    assign lcd_timing = div_cnt[LOW_TAP_BASE + 4];
    assign divider_event = div_overflow;

    // ------------------------------------------------------------
    // reset sources and stretch
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            rst_pin_s1 <= 1'b0;
            rst_pin_s2 <= 1'b0;
            sw_s1 <= 1'b0;
            sw_s2 <= 1'b0;
        end
        else
        begin
            rst_pin_s1 <= RESET_ACTIVE_HIGH ? external_reset_pin :
                ~external_reset_pin;
            rst_pin_s2 <= rst_pin_s1;
            sw_s1 <= switch_input_1 & switch_input_2 & switch_input_3 &
                switch_input_4;
            sw_s2 <= sw_s1;
        end
    end

    assign rst_request = rst_pin_s2 |
        (SWITCH_RESET_ENABLE & sw_s2);

    // presetn is power rise; without power-on clear flag clears one cycle after it
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            rst_state <= ST_POR;
        else
        begin
            case (rst_state)
                ST_POR:
                    rst_state <= POR_ENABLE ? ST_HOLD : ST_RUN;
                ST_HOLD:
                    if (!rst_request && div_overflow)
                        rst_state <= ST_RUN;
                ST_RUN:
                    if (rst_request)
                        rst_state <= ST_HOLD;
                default:
                    rst_state <= ST_HOLD;
            endcase
        end
    end

    assign reset_flag = (rst_state != ST_RUN);
    assign logic_reset = reset_flag;

    // ------------------------------------------------------------
    // alarm output
    // ------------------------------------------------------------
    always_comb
    begin
        case (alarm_ctrl[ALM_LOSEL_LSB +: 2])
            2'h0: low_tap = div_cnt[LOW_TAP_BASE];
            2'h1: low_tap = div_cnt[LOW_TAP_BASE + 1];
            2'h2: low_tap = div_cnt[LOW_TAP_BASE + 2];
            default: low_tap = 1'b0;
        endcase
    end

    assign high_comb = |(div_cnt[HIGH_TAP_BASE +: HIGH_TAPS] &
        alarm_ctrl[ALM_HIMASK_LSB +: HIGH_TAPS]);

    always_comb
    begin
        case (alarm_ctrl[ALM_MODSEL_LSB +: 2])
            2'h0: alarm_mod = div_cnt[MOD_TAP_4K];
            2'h1: alarm_mod = div_cnt[MOD_TAP_2K];
            default: alarm_mod = div_cnt[MOD_TAP_1K];
        endcase
    end

    always_comb
    begin
        case (alarm_ctrl[ALM_MODE_LSB +: 2])
            ALM_MODE_LOW: alarm_raw = low_tap;
            ALM_MODE_HIGH: alarm_raw = high_comb;
            default: alarm_raw = alarm_ctrl[ALM_SRC_BIT];
        endcase
        if (alarm_ctrl[ALM_MOD_EN_BIT])
            alarm_raw = alarm_raw & alarm_mod;
    end

    // ------------------------------------------------------------
    // dedicated outputs, registered
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            aux_output_1 <= AUX1_RESET_LEVEL;
            aux_output_2 <= AUX2_RESET_LEVEL;
            light_output <= LIGHT_RESET_LEVEL;
            alarm_output <= ALARM_RESET_LEVEL;
        end
        else if (logic_reset)
        begin
            aux_output_1 <= AUX1_RESET_LEVEL;
            aux_output_2 <= AUX2_RESET_LEVEL;
            light_output <= LIGHT_RESET_LEVEL;
            alarm_output <= ALARM_RESET_LEVEL;
        end
        else
        begin
            aux_output_1 <= out_ctrl[0];
            aux_output_2 <= out_ctrl[1];
            light_output <= out_ctrl[2];
            alarm_output <= alarm_raw;
        end
    end

    // commons held low: lit segments see full swing, unlit see none
    assign lcd_reset_force = logic_reset;
    assign lcd_common_level = '0;
    assign segment_level = {SEGMENTS{LCD_ALL_ON}};

    // ------------------------------------------------------------
    // apb slave, zero wait states
    // ------------------------------------------------------------
    assign apb_wr = psel & penable & pwrite;
    assign apb_rd = psel & ~penable & ~pwrite;
    assign pready = 1'b1;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            alarm_ctrl <= ALARM_CTRL_RST;
        else if (logic_reset)
            alarm_ctrl <= ALARM_CTRL_RST;
        else if (apb_wr && paddr == ADDR_ALARM_CTRL)
            alarm_ctrl <= pwdata;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            out_ctrl <= OUT_CTRL_RST;
        else if (logic_reset)
            out_ctrl <= OUT_CTRL_RST;
        else if (apb_wr && paddr == ADDR_OUT_CTRL)
            out_ctrl <= pwdata[3:0];
    end

    // any reset source restarts the rc oscillator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            osc_stop <= 1'b0;
        else if (rst_request)
            osc_stop <= 1'b0;
        else if (apb_wr && paddr == ADDR_OSC_CTRL &&
                 OSC_OPTION != OSC_XTAL)
            osc_stop <= pwdata[OSC_STOP_BIT];
    end

    // read data is registered in the setup cycle
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (apb_rd)
        begin
            case (paddr)
                ADDR_ALARM_CTRL: prdata <= alarm_ctrl;
                ADDR_OSC_CTRL: prdata <= {31'h0, osc_stop};
                ADDR_STATUS: prdata <= 32'((reset_flag << ST_RESET_BIT) |
                    (osc_stop << ST_STOP_BIT) |
                    (32'(OSC_OPTION) << ST_OSCOPT_LSB));
                ADDR_DIVIDER: prdata <= {17'h0, div_cnt};
                ADDR_OUT_CTRL: prdata <= {28'h0, out_ctrl};
                default: prdata <= 32'h0000_0000;
            endcase
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    sequence s_req;
        rst_request;
    endsequence
    sequence s_held;
        logic_reset [*2];
    endsequence
    property p_out_reset;
        @(posedge pclk) disable iff (!presetn)
        logic_reset |=> (aux_output_1 == AUX1_RESET_LEVEL) &&
            (alarm_output == ALARM_RESET_LEVEL);
    endproperty
    a_out_reset: assert property (p_out_reset)
        else $error("output not at reset level");
    property p_req_sets;
        @(posedge pclk) disable iff (!presetn)
        s_req |=> s_held;
    endproperty
    a_req_sets: assert property (p_req_sets)
        else $error("reset request did not set flag");
    property p_div_clear;
        @(posedge pclk) disable iff (!presetn)
        rst_request |=> (div_cnt == '0);
    endproperty
    a_div_clear: assert property (p_div_clear)
        else $error("divider not cleared");
    // power-rise release without power-on clear needs no overflow
    property p_flag_clear;
        @(posedge pclk) disable iff (!presetn)
        $fell(logic_reset) && ($past(rst_state) == ST_HOLD) |->
            $past(div_overflow);
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("flag cleared without overflow");
    property p_no_cycle;
        @(posedge pclk) disable iff (!presetn)
        logic_reset |-> !cycle_strobe;
    endproperty
    a_no_cycle: assert property (p_no_cycle)
        else $error("cycle during reset");
    property p_stop;
        @(posedge pclk) disable iff (!presetn)
        osc_stop |-> !rc_osc_run && !cycle_strobe;
    endproperty
    a_stop: assert property (p_stop)
        else $error("rc oscillator runs while stopped");
    property p_sync;
        @(posedge pclk) disable iff (!presetn)
        $rose(rst_pin_s2) |-> $past(external_reset_pin, 2) ==
            RESET_ACTIVE_HIGH;
    endproperty
    a_sync: assert property (p_sync)
        else $error("reset pin not synchronised");
    property p_alarm_mute;
        @(posedge pclk) disable iff (!presetn)
        !logic_reset && !$past(logic_reset) &&
        $past(alarm_ctrl[ALM_MOD_EN_BIT]) && !$past(alarm_mod)
        |-> !alarm_output;
    endproperty
    a_alarm_mute: assert property (p_alarm_mute)
        else $error("modulation gate ignored");
endmodule : dar_top

//--- testbench/dar_far_side.sv
// Purpose: far side of the block: oscillators, reset source, switches
// Assumes: oscillator ticks are one-cycle enables on pclk
// Notes: crystal ticks every cycle so a reset stretch stays short
`timescale 1ns/1ps
module dar_far_side
#(
    parameter bit ACTIVE_HIGH = 1'b0
)
(
    // clock
    input wire logic pclk,
    // commands from the bench
    input wire logic xtal_en,
    input wire logic pin_req,
    input wire logic [3:0] sw_req,
    // lines into the block
    output logic primary_osc_tick = 1'b0,
    output logic crystal_tick = 1'b0,
    output logic external_reset_pin = ~ACTIVE_HIGH,
    output logic [3:0] switch_level = 4'h0
);
    logic [1:0] phase = 2'h0;
    // -------------------------------------------------
    // sources, all moved just after the rising edge
    // -------------------------------------------------
    always @(posedge pclk)
    begin
        // primary period of three pclk cycles
        phase <= (phase == 2'h2) ? 2'h0 : phase + 2'h1;
        primary_osc_tick <= (phase == 2'h0);
        crystal_tick <= xtal_en;
        external_reset_pin <= pin_req ~^ ACTIVE_HIGH;
        switch_level <= sw_req;
    end
endmodule : dar_far_side

//--- testbench/divider_alarm_reset_control_tb.sv
// Purpose: self-checking bench for the divider, alarm and reset block
// Assumes: fast crystal ticks, low-active reset pin, no power-on clear
// Notes: alarm compared while the divider is frozen
`timescale 1ns/1ps
module divider_alarm_reset_control_tb;
    import dar_pkg::*;
    // -------------------------------------------------
    // signals
    // -------------------------------------------------
    // alarm, light, aux2, aux1 levels while reset holds
    localparam logic [3:0] RST_LVL = 4'h8;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [3:1] lcd_common_level;
    logic xtal_en = 1'b1;
    logic pin_req = 1'b0;
    logic [3:0] sw_req = 4'h0;
    logic [3:0] sw;
    logic ptick, xtick, pin, rc_osc_run, cycle_strobe, logic_reset;
    logic timer_clock, lcd_timing, lcd_reset_force;
    logic aux_output_1, aux_output_2, light_output, alarm_output;
    logic [DIV_STAGES:1] divider_tap;
    logic [41:0] segment_level;
    int num_errors = 0;
    int check_count = 0;
    int seed = 30145;

    dar_far_side dar_far_side_inst
    (
        .pclk, .xtal_en, .pin_req, .sw_req,
        .primary_osc_tick(ptick), .crystal_tick(xtick),
        .external_reset_pin(pin), .switch_level(sw)
    );
    dar_top #(.OSC_OPTION(OSC_CF_XTAL), .POR_ENABLE(1'b0),
        .RESET_ACTIVE_HIGH(1'b0), .ALARM_RESET_LEVEL(1'b1),
        .LCD_ALL_ON(1'b1)) dar_top_inst
    (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .primary_osc_tick(ptick),
        .crystal_tick(xtick), .rc_osc_run, .external_reset_pin(pin),
        .switch_input_1(sw[0]), .switch_input_2(sw[1]),
        .switch_input_3(sw[2]), .switch_input_4(sw[3]),
        .cycle_strobe, .logic_reset, .divider_tap, .timer_clock,
        .lcd_timing, .divider_event(), .aux_output_1, .aux_output_2,
        .light_output, .alarm_output, .lcd_reset_force,
        .lcd_common_level, .segment_level
    );

    initial
    begin
        forever #2 pclk = ~pclk;
    end
    // -------------------------------------------------
    // reporting
    // -------------------------------------------------
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, check_count);
        if (num_errors == 0 && check_count > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : complete_run

    task automatic check_word(input logic [31:0] got,
        input logic [31:0] exp, input string m);
        check_count++;
        if (got !== exp)
        begin
            num_errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, got,
                exp);
        end
    endtask : check_word

    task automatic timed_out();
        num_errors++;
        $display("mismatch at %0t: wait ran out", $time);
        complete_run();
    endtask : timed_out

    task automatic apb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // hold until pready is seen high at an edge
        do
        begin
            @(posedge pclk);
            n++;
            if (n > 16)
                timed_out();
        end
        while (pready !== 1'b1);
        r = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wait_flag(input logic lvl, input int lim, output int n);
        n = 0;
        while (logic_reset !== lvl)
        begin
            @(posedge pclk);
            #1;
            n++;
            if (n > lim)
                timed_out();
        end
    endtask : wait_flag

    task automatic check_levels();
        check_word({28'h0, alarm_output, light_output, aux_output_2,
            aux_output_1}, {28'h0, RST_LVL}, "reset levels");
        check_word({31'h0, &segment_level}, 32'h1, "segments");
        check_word({29'h0, lcd_common_level}, 32'h0, "commons");
        check_word({31'h0, lcd_reset_force}, 32'h1, "lcd force");
        check_word({31'h0, cycle_strobe}, 32'h0, "strobe held");
    endtask : check_levels

    // alarm level worked out from the control word and frozen taps
    function automatic logic alarm_exp(input logic [31:0] c,
        input logic [DIV_STAGES:1] t);
        logic b;
        case (c[1:0])
            ALM_MODE_LOW: b = t[LOW_TAP_BASE + int'(c[3:2])];
            ALM_MODE_HIGH: b = |(t[DIV_STAGES:HIGH_TAP_BASE] & c[9:4]);
            default: b = c[ALM_SRC_BIT];
        endcase
        // a gated static level is how a modulated tone is sent
        if (c[ALM_MOD_EN_BIT])
            b = b & t[MOD_TAP_4K + int'(c[11:10])];
        return b;
    endfunction : alarm_exp

    // -------------------------------------------------
    // main sequence
    // -------------------------------------------------
    initial
    begin : main
        logic [31:0] r;
        logic [31:0] c;
        int n;
        int t;
        repeat (3) @(posedge pclk);
        #1;
        check_levels();
        @(posedge pclk);
        presetn <= 1'b1;
        wait_flag(1'b0, 4, n);
        apb(1'b0, ADDR_STATUS, 32'h0, r);
        check_word(r & 32'h73, 32'h10, "status");
        check_word({31'h0, pslverr}, 32'h0, "error flag");
        apb(1'b0, 8'h3c, 32'h0, r);
        check_word(r, 32'h0, "unmapped read");
        // primary ticks in one instruction cycle
        n = 0;
        t = 0;
        while (cycle_strobe !== 1'b1)
        begin
            @(posedge pclk);
            #1;
            if (++n > 200)
                timed_out();
        end
        do
        begin
            t += int'(ptick === 1'b1);
            @(posedge pclk);
            #1;
            if (++n > 200)
                timed_out();
        end
        while (cycle_strobe !== 1'b1);
        check_word(32'(t), 32'(CF_CYCLE_DIV), "cycle ticks");
        for (int i = 0; i < 18; i++)
        begin
            r = $random(seed);
            c = {18'h0, r[13], i >= 9, 2'(i / 3 % 3), r[9:4],
                (r[3:2] == 2'h3) ? 2'h0 : r[3:2], 2'(i % 3)};
            apb(1'b1, ADDR_ALARM_CTRL, c, r);
            apb(1'b1, ADDR_OUT_CTRL, {29'h0, c[6:4]}, r);
            r = $random(seed);
            xtal_en <= 1'b1;
            repeat (int'(r[9:0]) + 1) @(posedge pclk);
            xtal_en <= 1'b0;
            repeat (5) @(posedge pclk);
            #1;
            check_word({31'h0, alarm_output}, {31'h0,
                alarm_exp(c, divider_tap)}, "alarm");
            check_word({30'h0, timer_clock, lcd_timing}, {30'h0,
                divider_tap[10], divider_tap[7]}, "taps");
            check_word({29'h0, light_output, aux_output_2, aux_output_1},
                {29'h0, c[6:4]}, "out ctrl");
        end
        xtal_en <= 1'b1;
        apb(1'b1, ADDR_OSC_CTRL, 32'h1, r);
        repeat (2) @(posedge pclk);
        #1;
        check_word({31'h0, rc_osc_run}, 32'h0, "osc stop");
        sw_req <= 4'h7;
        repeat (8) @(posedge pclk);
        #1;
        check_word({31'h0, logic_reset}, 32'h0, "three switches");
        sw_req <= 4'hf;
        wait_flag(1'b1, 8, n);
        // outputs are registered: one edge after the flag
        @(posedge pclk);
        #1;
        check_levels();
        check_word({31'h0, rc_osc_run}, 32'h1, "stop cleared");
        sw_req <= 4'h0;
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        wait_flag(1'b0, 4, n);
        apb(1'b1, ADDR_OUT_CTRL, 32'h7, r);
        pin_req <= 1'b1;
        wait_flag(1'b1, 8, n);
        repeat (4) @(posedge pclk);
        #1;
        check_word({17'h0, divider_tap}, 32'h0, "divider clear");
        check_levels();
        apb(1'b0, ADDR_STATUS, 32'h0, r);
        check_word(r & 32'h1, 32'h1, "flag set");
        pin_req <= 1'b0;
        wait_flag(1'b0, 33000, n);
        check_word(32'(n >= 32760 && n <= 32780), 32'h1,
            "stretch");
        @(posedge pclk);
        #1;
        check_word({28'h0, alarm_output, light_output, aux_output_2,
            aux_output_1}, 32'h0, "regs cleared");
        complete_run();
    end
endmodule : divider_alarm_reset_control_tb
